// ==== design/sacr_defines.svh ====
// Overview of operation
// - all registers read/write except identity and status
// - reset loads documented default into every bit
// - identity holds part code and revision code
// - status bits report clock error and overflows
// - channel power-down real only after global bit or both channels down
// - channel bit powers down or mutes stage
// - global bit gives low power, keeps registers
// - auto speed ignores field, uses detected ratio
// - speed field selects quarter/half/single/double rate
// - float: master floats all, slave data only
// - mic preamp and bias power-down default one
// - clock halving ignored in slave without auto
// - role bit: zero slave, one master
// - format bit: zero left-justified, one I2S
// - mix bit selects raw or processed data, processed only with engine enable bit set
// - differential mix bit outputs (A-B)/2 mono
// - engine enable bit routes converter data
`ifndef SACR_DEFINES_SVH
`define SACR_DEFINES_SVH

`define SACR_ADDR_ID      8'h01
`define SACR_ADDR_PWR     8'h02
`define SACR_ADDR_MICSPD  8'h03
`define SACR_ADDR_IFC     8'h04
`define SACR_ADDR_ENG     8'h09
`define SACR_ADDR_RRATE   8'h1d
`define SACR_ADDR_THRESH  8'h1e
`define SACR_ADDR_GATE    8'h1f
`define SACR_ADDR_STATUS  8'h20
`define SACR_ADDR_RSVD21  8'h21

`define SACR_RST_PWR      8'h00
`define SACR_RST_MICSPD   8'hae
`define SACR_RST_IFC      8'h00
`define SACR_RST_ENG      8'h02
`define SACR_RST_RRATE    8'h3f
`define SACR_RST_THRESH   8'h00
`define SACR_RST_GATE     8'h00
`define SACR_RST_STATUS   8'h00
`define SACR_RST_RSVD21   8'h50
`define SACR_UNMAPPED     8'h00

// arbitrary neutral identity values
`define SACR_PART_CODE    5'h0a
`define SACR_REV_CODE     3'h2

// power control fields
`define SACR_PWR_GLOBAL   0
`define SACR_PWR_CONV_A   1
`define SACR_PWR_CONV_B   2
`define SACR_PWR_AMP_A    3
`define SACR_PWR_AMP_B    4
// mic power and speed fields
`define SACR_MS_HALVE     0
`define SACR_MS_BIAS      1
`define SACR_MS_MIC_A     2
`define SACR_MS_MIC_B     3
`define SACR_MS_FLOAT     4
`define SACR_MS_SPD_LO    5
`define SACR_MS_SPD_HI    6
`define SACR_MS_AUTO      7
// interface fields
`define SACR_IF_DIFFMIX   0
`define SACR_IF_PROC      1
`define SACR_IF_FMT       2
`define SACR_IF_MASTER    6
// engine control field
`define SACR_ENG_SRC      6
// status field width
`define SACR_STATUS_BITS  7

`endif

// ==== design/sacr_pkg.sv ====
package sacr_pkg;
  // speed modes in field encoding
  typedef enum logic [1:0] {
    SACR_DOUBLE_RATE  = 2'h0,
    SACR_SINGLE_RATE  = 2'h1,
    SACR_HALF_RATE    = 2'h2,
    SACR_QUARTER_RATE = 2'h3
  } sacr_speed_t;

  // whole state of the register bank
  typedef struct packed {
    logic [7:0]  pwr;
    logic [7:0]  micspd;
    logic [7:0]  ifc;
    logic [7:0]  eng;
    logic [7:0]  rrate;
    logic [7:0]  thresh;
    logic [7:0]  gate;
    logic [7:0]  status;
    logic [7:0]  rsvd21;
    logic        armed;
    logic [7:0]  rdata;
    logic        low_power;
    logic [1:0]  conv_pd;
    logic [1:0]  conv_mute;
    logic [1:0]  amp_pd;
    logic [1:0]  amp_mute;
    logic [1:0]  mic_pd;
    logic        bias_pd;
    sacr_speed_t speed;
    logic        halve;
    logic        master;
    logic        clk_oe;
    logic        data_oe;
    logic        i2s;
    logic        processed;
    logic        diff_mix;
    logic        engine_src;
  } sacr_state_t;
endpackage

// ==== design/sacr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sacr_defines.svh"

module sacr_regs (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [6:0] status_events,
  input  wire logic [1:0] detected_speed,
  output logic      [7:0] reg_rdata,
  output logic            low_power,
  output logic      [1:0] conv_power_down,
  output logic      [1:0] conv_mute,
  output logic      [1:0] amp_power_down,
  output logic      [1:0] amp_mute,
  output logic      [1:0] mic_preamp_power_down,
  output logic            mic_bias_power_down,
  output logic      [1:0] speed_mode,
  output logic            master_clock_halve,
  output logic            master_mode,
  output logic            serial_clock_oe,
  output logic            serial_data_output_oe,
  output logic            output_format_select,
  output logic            processed_output_select,
  output logic            differential_mix_enable,
  output logic            engine_source_enable
);

  sacr_pkg::sacr_state_t s_r;
  sacr_pkg::sacr_state_t s_nxt;

  logic [7:0] id_word;
  logic [7:0] ms;
  logic [7:0] pw;

  // fixed identity word
  assign id_word = {`SACR_PART_CODE, `SACR_REV_CODE};

  // next state: writes, status, read data, derived controls
  always_comb begin
    s_nxt = s_r;
    if (reg_wr) begin
      case (reg_addr)
        `SACR_ADDR_PWR:    s_nxt.pwr = reg_wdata;
        `SACR_ADDR_MICSPD: s_nxt.micspd = reg_wdata;
        `SACR_ADDR_IFC:    s_nxt.ifc = reg_wdata;
        `SACR_ADDR_ENG:    s_nxt.eng = reg_wdata;
        `SACR_ADDR_RRATE:  s_nxt.rrate = reg_wdata;
        `SACR_ADDR_THRESH: s_nxt.thresh = reg_wdata;
        `SACR_ADDR_GATE:   s_nxt.gate = reg_wdata;
        `SACR_ADDR_RSVD21: s_nxt.rsvd21 = reg_wdata;
        default:           s_nxt.pwr = s_r.pwr;
      endcase
    end
    // read data, status cleared by a read
    if (reg_rd) begin
      case (reg_addr)
        `SACR_ADDR_ID:     s_nxt.rdata = id_word;
        `SACR_ADDR_PWR:    s_nxt.rdata = s_r.pwr;
        `SACR_ADDR_MICSPD: s_nxt.rdata = s_r.micspd;
        `SACR_ADDR_IFC:    s_nxt.rdata = s_r.ifc;
        `SACR_ADDR_ENG:    s_nxt.rdata = s_r.eng;
        `SACR_ADDR_RRATE:  s_nxt.rdata = s_r.rrate;
        `SACR_ADDR_THRESH: s_nxt.rdata = s_r.thresh;
        `SACR_ADDR_GATE:   s_nxt.rdata = s_r.gate;
        `SACR_ADDR_STATUS: s_nxt.rdata = s_r.status;
        `SACR_ADDR_RSVD21: s_nxt.rdata = s_r.rsvd21;
        default:           s_nxt.rdata = `SACR_UNMAPPED;
      endcase
      if (reg_addr == `SACR_ADDR_STATUS) begin
        s_nxt.status = 8'h00;
      end
    end
    // sticky events, a set wins over the read clear
    s_nxt.status[`SACR_STATUS_BITS-1:0] = s_nxt.status[`SACR_STATUS_BITS-1:0]
                                          | status_events;
    s_nxt.status[7] = 1'b0;
    // arming of real channel power-down
    pw = s_r.pwr;
    ms = s_r.micspd;
    if (pw[`SACR_PWR_GLOBAL]
        || (pw[`SACR_PWR_CONV_A] && pw[`SACR_PWR_CONV_B])
        || (pw[`SACR_PWR_AMP_A] && pw[`SACR_PWR_AMP_B])) begin
      s_nxt.armed = 1'b1;
    end else if (pw[`SACR_PWR_AMP_B:`SACR_PWR_CONV_A] == 4'h0) begin
      s_nxt.armed = 1'b0;
    end
    // power controls
    s_nxt.low_power = pw[`SACR_PWR_GLOBAL];
    s_nxt.conv_pd   = pw[`SACR_PWR_CONV_B:`SACR_PWR_CONV_A]
                      & {2{s_r.armed}};
    s_nxt.conv_mute = pw[`SACR_PWR_CONV_B:`SACR_PWR_CONV_A]
                      & {2{~s_r.armed}};
    s_nxt.amp_pd    = pw[`SACR_PWR_AMP_B:`SACR_PWR_AMP_A]
                      & {2{s_r.armed}};
    s_nxt.amp_mute  = pw[`SACR_PWR_AMP_B:`SACR_PWR_AMP_A]
                      & {2{~s_r.armed}};
    s_nxt.mic_pd    = ms[`SACR_MS_MIC_B:`SACR_MS_MIC_A];
    s_nxt.bias_pd   = ms[`SACR_MS_BIAS];
    // speed and clocking
    if (ms[`SACR_MS_AUTO]) begin
      s_nxt.speed = sacr_pkg::sacr_speed_t'(detected_speed);
    end else begin
      s_nxt.speed = sacr_pkg::sacr_speed_t'(ms[`SACR_MS_SPD_HI:`SACR_MS_SPD_LO]);
    end
    s_nxt.master = s_r.ifc[`SACR_IF_MASTER];
    s_nxt.halve  = ms[`SACR_MS_HALVE]
                   & (s_r.ifc[`SACR_IF_MASTER] | ms[`SACR_MS_AUTO]);
    // serial port drive
    s_nxt.clk_oe  = s_r.ifc[`SACR_IF_MASTER] & ~ms[`SACR_MS_FLOAT];
    s_nxt.data_oe = ~ms[`SACR_MS_FLOAT];
    // format and routing
    s_nxt.i2s        = s_r.ifc[`SACR_IF_FMT];
    s_nxt.engine_src = s_r.eng[`SACR_ENG_SRC];
    s_nxt.processed  = s_r.ifc[`SACR_IF_PROC] & s_r.eng[`SACR_ENG_SRC];
    s_nxt.diff_mix   = s_r.ifc[`SACR_IF_DIFFMIX];
  end

  // state register with synchronous reset to defaults
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r            <= '0;
      s_r.pwr        <= `SACR_RST_PWR;
      s_r.micspd     <= `SACR_RST_MICSPD;
      s_r.ifc        <= `SACR_RST_IFC;
      s_r.eng        <= `SACR_RST_ENG;
      s_r.rrate      <= `SACR_RST_RRATE;
      s_r.thresh     <= `SACR_RST_THRESH;
      s_r.gate       <= `SACR_RST_GATE;
      s_r.status     <= `SACR_RST_STATUS;
      s_r.rsvd21     <= `SACR_RST_RSVD21;
      s_r.mic_pd     <= 2'h3;
      s_r.bias_pd    <= 1'b1;
      s_r.speed      <= sacr_pkg::SACR_SINGLE_RATE;
      s_r.data_oe    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata               = s_r.rdata;
  assign low_power               = s_r.low_power;
  assign conv_power_down         = s_r.conv_pd;
  assign conv_mute               = s_r.conv_mute;
  assign amp_power_down          = s_r.amp_pd;
  assign amp_mute                = s_r.amp_mute;
  assign mic_preamp_power_down   = s_r.mic_pd;
  assign mic_bias_power_down     = s_r.bias_pd;
  assign speed_mode              = s_r.speed;
  assign master_clock_halve      = s_r.halve;
  assign master_mode             = s_r.master;
  assign serial_clock_oe         = s_r.clk_oe;
  assign serial_data_output_oe   = s_r.data_oe;
  assign output_format_select    = s_r.i2s;
  assign processed_output_select = s_r.processed;
  assign differential_mix_enable = s_r.diff_mix;
  assign engine_source_enable    = s_r.engine_src;

  // checks on the bank
  a_id_readback: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `SACR_ADDR_ID |=> reg_rdata == id_word)
    else $error("identity read mismatch");

  a_ro_status_kept: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && !reg_rd && reg_addr == `SACR_ADDR_STATUS
    |=> s_r.status == ($past(s_r.status) | {1'b0, $past(status_events)}))
    else $error("status changed by write");

  a_event_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    status_events[6] |=> s_r.status[6])
    else $error("status event lost");

  a_reset_mic: assert property (@(posedge clk)
    !rst_n |=> s_r.micspd == `SACR_RST_MICSPD && s_r.rrate == `SACR_RST_RRATE)
    else $error("reset default wrong");

  a_rw_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `SACR_ADDR_IFC |=> s_r.ifc == $past(reg_wdata)
    ##1 master_mode == $past(s_r.ifc[`SACR_IF_MASTER]))
    else $error("interface write lost");

  a_mute_not_pd: assert property (@(posedge clk) disable iff (!rst_n)
    (conv_mute & conv_power_down) == 2'h0)
    else $error("channel both muted and down");

  a_global_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    low_power && !reg_wr |=> $stable(s_r.micspd) && $stable(s_r.ifc))
    else $error("registers lost in low power");

  a_auto_speed: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.micspd[`SACR_MS_AUTO] && $stable(s_r.micspd) |=> speed_mode == $past(detected_speed))
    else $error("auto speed not followed");

  a_float_slave: assert property (@(posedge clk) disable iff (!rst_n)
    !serial_data_output_oe |-> !serial_clock_oe)
    else $error("clock driven while floating");

  a_halve_slave: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.ifc[`SACR_IF_MASTER] && !s_r.micspd[`SACR_MS_AUTO] |=> !master_clock_halve)
    else $error("halving in slave without auto");

  a_proc_route: assert property (@(posedge clk) disable iff (!rst_n)
    processed_output_select |-> $past(s_r.eng[`SACR_ENG_SRC]) && $past(s_r.ifc[`SACR_IF_PROC]))
    else $error("processed route without engine");

  // register writes land, read data holds, outputs follow their fields
  a_pwr_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `SACR_ADDR_PWR |=> s_r.pwr == $past(reg_wdata))
    else $error("power write lost");

  a_micspd_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `SACR_ADDR_MICSPD |=> s_r.micspd == $past(reg_wdata))
    else $error("mic and speed write lost");

  a_eng_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `SACR_ADDR_ENG |=> s_r.eng == $past(reg_wdata))
    else $error("engine write lost");

  a_thresh_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `SACR_ADDR_THRESH |=> s_r.thresh == $past(reg_wdata))
    else $error("threshold write lost");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");

  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `SACR_ADDR_STATUS |=> s_r.status == {1'b0, $past(status_events)})
    else $error("status not cleared by read");

  a_low_power: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> low_power == $past(s_r.pwr[`SACR_PWR_GLOBAL]))
    else $error("low power not following global bit");

  a_arm_global: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.pwr[`SACR_PWR_GLOBAL] |=> s_r.armed)
    else $error("global down did not arm channels");

  a_unarmed_no_pd: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.armed |=> conv_power_down == 2'h0 && amp_power_down == 2'h0)
    else $error("channel powered down without arming");

  a_armed_pd: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.armed |=> conv_power_down == $past(s_r.pwr[`SACR_PWR_CONV_B:`SACR_PWR_CONV_A])
    && amp_power_down == $past(s_r.pwr[`SACR_PWR_AMP_B:`SACR_PWR_AMP_A]))
    else $error("armed channel not powered down");

  a_unarmed_mute: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.armed |=> conv_mute == $past(s_r.pwr[`SACR_PWR_CONV_B:`SACR_PWR_CONV_A])
    && amp_mute == $past(s_r.pwr[`SACR_PWR_AMP_B:`SACR_PWR_AMP_A]))
    else $error("unarmed channel not muted");

  a_mic_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mic_preamp_power_down == $past(s_r.micspd[`SACR_MS_MIC_B:`SACR_MS_MIC_A]))
    else $error("preamp power-down wrong");

  a_bias_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mic_bias_power_down == $past(s_r.micspd[`SACR_MS_BIAS]))
    else $error("bias power-down wrong");

  a_fixed_speed: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.micspd[`SACR_MS_AUTO]
    |=> speed_mode == $past(s_r.micspd[`SACR_MS_SPD_HI:`SACR_MS_SPD_LO]))
    else $error("fixed speed not followed");

  a_role_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> master_mode == $past(s_r.ifc[`SACR_IF_MASTER]))
    else $error("role output wrong");

  a_master_drive: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ifc[`SACR_IF_MASTER] && !s_r.micspd[`SACR_MS_FLOAT] |=> serial_clock_oe)
    else $error("master clocks not driven");

  a_slave_clk_in: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.ifc[`SACR_IF_MASTER] |=> !serial_clock_oe)
    else $error("slave drives clock pins");

  a_data_float: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> serial_data_output_oe == !$past(s_r.micspd[`SACR_MS_FLOAT]))
    else $error("data output drive wrong");

  a_halve_master: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ifc[`SACR_IF_MASTER] |=> master_clock_halve == $past(s_r.micspd[`SACR_MS_HALVE]))
    else $error("halving not honoured as master");

  a_format_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> output_format_select == $past(s_r.ifc[`SACR_IF_FMT]))
    else $error("format select wrong");

  a_raw_route: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.ifc[`SACR_IF_PROC] |=> !processed_output_select)
    else $error("processed route without mix bit");

  a_diff_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> differential_mix_enable == $past(s_r.ifc[`SACR_IF_DIFFMIX]))
    else $error("differential mix wrong");

  a_engine_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> engine_source_enable == $past(s_r.eng[`SACR_ENG_SRC]))
    else $error("engine source wrong");

endmodule // sacr_regs
`default_nettype wire

// ==== tb/sacr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sacr_defines.svh"

// host side of the control port
module sacr_host (
  input  wire logic       clk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  // idle port at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // one-cycle write; reserved register left alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a != `SACR_ADDR_RSVD21) begin
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= (a == `SACR_ADDR_PWR) ? (d | 8'h60) : d;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask

  // one-cycle read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask

  // channel power-down: whole part down, channels, whole part up
  task automatic pdown_seq(input logic [7:0] ch);
    wr(`SACR_ADDR_PWR, 8'h01);
    repeat (4) @(posedge clk);
    wr(`SACR_ADDR_PWR, ch | 8'h01);
    repeat (4) @(posedge clk);
    wr(`SACR_ADDR_PWR, ch);
  endtask
endmodule  // sacr_host
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sacr_defines.svh"

module tb_top;
  logic clk, rst_n, reg_wr, reg_rd;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] status_events;
  logic [1:0] detected_speed, conv_power_down, conv_mute, amp_power_down, amp_mute;
  logic [1:0] mic_preamp_power_down, speed_mode;
  logic low_power, mic_bias_power_down, master_clock_halve, master_mode;
  logic serial_clock_oe, serial_data_output_oe, output_format_select;
  logic processed_output_select, differential_mix_enable, engine_source_enable;
  logic [7:0] q[$];
  int n_mismatch, compares, cyc;
  localparam logic [7:0] DA [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h09, 8'h1d, 8'h1e,
                                     8'h1f, 8'h20, 8'h21, 8'h7f};
  localparam logic [7:0] DV [11] = '{{`SACR_PART_CODE, `SACR_REV_CODE}, 8'h00, 8'hae,
                                     8'h00, 8'h02, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00};
  localparam logic [7:0] RA [7] = '{8'h02, 8'h03, 8'h04, 8'h09, 8'h1d, 8'h1e, 8'h1f};
  localparam logic [7:0] MK [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hfc, 8'hff};

  sacr_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .status_events(status_events),
    .detected_speed(detected_speed), .reg_rdata(reg_rdata), .low_power(low_power),
    .conv_power_down(conv_power_down), .conv_mute(conv_mute),
    .amp_power_down(amp_power_down), .amp_mute(amp_mute),
    .mic_preamp_power_down(mic_preamp_power_down), .mic_bias_power_down(mic_bias_power_down),
    .speed_mode(speed_mode), .master_clock_halve(master_clock_halve),
    .master_mode(master_mode), .serial_clock_oe(serial_clock_oe),
    .serial_data_output_oe(serial_data_output_oe),
    .output_format_select(output_format_select),
    .processed_output_select(processed_output_select),
    .differential_mix_enable(differential_mix_enable),
    .engine_source_enable(engine_source_enable));
  sacr_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  // clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t output got %h exp %h", $time, got, exp);
    end
  endtask

  // read data lands one cycle after the read edge
  always @(posedge clk) begin
    if (rd_d) begin
      chk_rd(reg_rdata, q.pop_front());
    end
    rd_d <= reg_rd & rst_n;
  end

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    u_host.rd(a);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic defaults();
    for (int i = 0; i < 11; i++) rd_exp(DA[i], DV[i]);
    settle();
    chk_out({2'h0, mic_preamp_power_down, mic_bias_power_down, speed_mode,
             serial_data_output_oe}, {2'h0, 2'h3, 1'b1, detected_speed, 1'b1});
  endtask
  task automatic close_out();
    repeat (3) @(posedge clk);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    int seed;
    logic [7:0] d;
    seed = 32'hff3d;
    {rst_n, status_events, detected_speed} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    defaults();
    // random read-write, then writes to read-only places
    for (int i = 0; i < 7; i++) begin
      d = 8'($random(seed)) & MK[i];
      u_host.wr(RA[i], d);
      rd_exp(RA[i], (RA[i] == 8'h02) ? (d | 8'h60) : d);
    end
    u_host.wr(8'h01, 8'($random(seed)));
    u_host.wr(8'h20, 8'($random(seed)));
    rd_exp(8'h01, DV[0]);
    rd_exp(8'h20, 8'h00);
    do_reset();
    defaults();
    // each status event sticks, clears on read
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      status_events <= 7'(1 << i);
      @(posedge clk);
      status_events <= 7'h00;
      rd_exp(8'h20, 8'(1 << i));
      rd_exp(8'h20, 8'h00);
    end
    // event in the clearing read's cycle survives the clear
    fork
      rd_exp(8'h20, 8'h00);
      begin
        @(posedge clk);
        status_events <= 7'h01;
        @(posedge clk);
        status_events <= 7'h00;
      end
    join
    rd_exp(8'h20, 8'h01);
    // fixed speed field, then detected speed
    for (int s = 0; s < 4; s++) begin
      u_host.wr(8'h03, {1'b0, 2'(s), 5'h0e});
      detected_speed <= 2'(~s);
      settle();
      chk_out({6'h0, speed_mode}, 8'(s));
    end
    u_host.wr(8'h03, 8'hae);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      detected_speed <= 2'(s);
      settle();
      chk_out({6'h0, speed_mode}, 8'(s));
    end
    // role, float, halving and routing bits
    u_host.wr(8'h09, 8'h42);
    for (int i = 0; i < 16; i++) begin
      u_host.wr(8'h03, {3'b001, i[2], 3'b111, i[1]});
      u_host.wr(8'h04, {1'b0, i[3], 3'b000, {3{i[0]}}});
      settle();
      chk_out({7'h0, master_mode}, {7'h0, i[3]});
      chk_out({6'h0, serial_clock_oe, serial_data_output_oe}, {6'h0, i[3] & ~i[2], ~i[2]});
      chk_out({7'h0, master_clock_halve}, {7'h0, i[3] & i[1]});
      chk_out({4'h0, output_format_select, processed_output_select, differential_mix_enable,
               engine_source_enable}, {4'h0, {3{i[0]}}, 1'b1});
    end
    u_host.wr(8'h09, 8'h02);
    settle();
    chk_out({7'h0, processed_output_select}, 8'h00);
    // single channel bits only mute
    u_host.wr(8'h02, 8'h0c);
    settle();
    chk_out({conv_power_down, conv_mute, amp_power_down, amp_mute}, 8'h21);
    u_host.wr(8'h02, 8'h01);
    settle();
    chk_out({7'h0, low_power}, 8'h01);
    rd_exp(8'h04, 8'h47);
    u_host.pdown_seq(8'h1e);
    settle();
    chk_out({conv_power_down, conv_mute, amp_power_down, amp_mute}, 8'hcc);
    chk_out({7'h0, low_power}, 8'h00);
    close_out();
  end
endmodule  // tb_top
`default_nettype wire
